// [inc/xcvr_prot_pkg.sv]
// constants and types for the transceiver protection supervisor
package xcvr_prot_pkg;
  localparam int unsigned CLK_FREQ_HZ      = 100_000_000;
  localparam int unsigned RECOVERY_TIME_US = 200;
  localparam int unsigned RECOVERY_CYCLES  = RECOVERY_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned UV_FILTER_TIME_US = 100;
  localparam int unsigned UV_FILTER_CYCLES  = UV_FILTER_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned CNT_W             = 32;

  localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] ADDR_IRQST  = 32'h0000_0008;
  localparam logic [31:0] ADDR_MASK   = 32'h0000_000C;

  localparam logic [1:0]  CTRL_RESET  = 2'h0;
  localparam logic [3:0]  MASK_RESET  = 4'h0;

  // event bits: 0 thermal, 1 battery uv, 2 core uv, 3 io uv
  localparam int unsigned EV_W = 4;

  typedef enum logic [5:0] {
    MODE_NORMAL  = 6'b000001,
    MODE_SILENT  = 6'b000010,
    MODE_STANDBY = 6'b000100,
    MODE_SLEEP   = 6'b001000,
    MODE_OFF     = 6'b010000,
    MODE_RECOVER = 6'b100000
  } op_mode_t;
endpackage

// [hw/can_xcvr_fault_protection.sv]
// protection supervisor for a CAN FD transceiver, with APB registers
`timescale 1ns/1ps
module can_xcvr_fault_protection
  import xcvr_prot_pkg::*;
#(
  parameter int unsigned RECOVERY_CNT  = RECOVERY_CYCLES,
  parameter int unsigned UV_FILTER_CNT = UV_FILTER_CYCLES
)(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        temp_above_trip_i,
  input  wire logic        temp_below_release_i,
  input  wire logic        battery_supply_undervoltage_i,
  input  wire logic        core_supply_undervoltage_i,
  input  wire logic        io_supply_undervoltage_i,
  input  wire logic        txd_i,
  input  wire logic        bus_rx_i,
  output logic             bus_drive_dominant_o,
  output logic             bus_bias_recessive_o,
  output logic             receiver_enable_o,
  output logic             rxd_o,
  output logic             wake_detect_enable_o,
  output logic             autonomous_active_o,
  output logic             fault_indicator_n_o,
  output logic             irq_o
);

  logic [4:0]     sync1;
  logic [4:0]     sync2;
  logic [1:0]     txd_s;
  logic [1:0]     rx_s;
  logic           over_temperature_shutdown;
  logic           uv_bat;
  logic           uv_core;
  logic           uv_io;
  logic           uv_any;
  logic           uv_filt;
  logic [CNT_W-1:0] uv_cnt;
  logic [CNT_W-1:0] rec_cnt;
  op_mode_t       mode;
  op_mode_t       next_mode;
  logic [1:0]     ctrl;
  logic [3:0]     irq_status;
  logic [3:0]     irq_mask;
  logic [3:0]     ev_prev;
  logic [3:0]     ev_now;
  logic [3:0]     ev_rise;
  logic           apb_acc;
  logic           rd_irq;
  logic           drive_ok;
  logic           uv_pend;

  // normal and silent are the modes with a live receive path
  function automatic logic is_active_mode(input op_mode_t m);
    return (m == MODE_NORMAL) || (m == MODE_SILENT);
  endfunction

  // run mode picked by the control register
  function automatic op_mode_t run_mode(input logic [1:0] c);
    if (c[1])
      return MODE_STANDBY;
    else if (c[0])
      return MODE_SILENT;
    else
      return MODE_NORMAL;
  endfunction

  // comparator inputs pass two flip-flops first
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end
    else
    begin
      sync1 <= {temp_below_release_i, temp_above_trip_i, battery_supply_undervoltage_i,
                core_supply_undervoltage_i, io_supply_undervoltage_i};
      sync2 <= sync1;
    end
  end

  // pin inputs idle recessive, so reset to high
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      txd_s <= 2'h3;
      rx_s  <= 2'h3;
    end
    else
    begin
      txd_s <= {txd_s[0], txd_i};
      rx_s  <= {rx_s[0], bus_rx_i};
    end
  end

  assign uv_io   = sync2[0];
  assign uv_core = sync2[1];
  assign uv_bat  = sync2[2];
  assign uv_any  = uv_bat | uv_core | uv_io;

  // thermal shutdown with hysteresis
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      over_temperature_shutdown <= 1'b0;
    else if (sync2[3])
      over_temperature_shutdown <= 1'b1;
    else if (sync2[4])
      over_temperature_shutdown <= 1'b0;
  end

  // undervoltage filter timer for core and io supplies
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      uv_cnt  <= '0;
      uv_filt <= 1'b0;
    end
    else if (!(uv_core | uv_io))
    begin
      uv_cnt  <= '0;
      uv_filt <= 1'b0;
    end
    else if (uv_cnt >= CNT_W'(UV_FILTER_CNT))
      uv_filt <= 1'b1;
    else
      uv_cnt <= uv_cnt + CNT_W'(1);
  end

  // recovery delay counter
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || mode != MODE_RECOVER || uv_any)
      rec_cnt <= '0;
    else
      rec_cnt <= rec_cnt + CNT_W'(1);
  end

  // any undervoltage leaves a recovery pending until the delay starts
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      uv_pend <= 1'b0;
    else if (uv_any)
      uv_pend <= 1'b1;
    else if (mode == MODE_RECOVER)
      uv_pend <= 1'b0;
  end

  // ctrl[0] selects silent instead of normal, ctrl[1] requests standby
  always_comb
  begin
    next_mode = mode;
    if (uv_bat)
      next_mode = MODE_OFF;
    else if (uv_filt)
      next_mode = MODE_SLEEP;
    else if (uv_io)
      next_mode = MODE_STANDBY;
    else if (uv_core)
      next_mode = mode;
    else if (uv_pend)
      next_mode = MODE_RECOVER;
    else
    begin
      case (mode)
        MODE_OFF, MODE_SLEEP:
          next_mode = MODE_RECOVER;
        MODE_RECOVER:
          if (rec_cnt >= CNT_W'(RECOVERY_CNT) - CNT_W'(1))
            next_mode = run_mode(ctrl);
        MODE_STANDBY, MODE_NORMAL, MODE_SILENT:
          next_mode = run_mode(ctrl);
        default:
          next_mode = MODE_RECOVER;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      mode <= MODE_RECOVER;
    else
      mode <= next_mode;
  end

  // bus side outputs
  assign drive_ok = (mode == MODE_NORMAL) && !over_temperature_shutdown && !uv_any;

  // driver follows transmit data only in normal mode with no fault
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      bus_drive_dominant_o <= 1'b0;
    else
      bus_drive_dominant_o <= drive_ok & ~txd_s[1];
  end

  // recessive bias whenever the driver is not enabled (drive_ok low), dropped in undervoltage
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      bus_bias_recessive_o <= 1'b0;
    else
      bus_bias_recessive_o <= ~uv_any & (over_temperature_shutdown | ~drive_ok);
  end

  // receiver stays on through thermal shutdown
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      receiver_enable_o <= 1'b0;
    else
      receiver_enable_o <= ~uv_any & is_active_mode(mode);
  end

  // receive data, parked high when the path is off
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      rxd_o <= 1'b1;
    else if (uv_core && !uv_io)
      rxd_o <= 1'b1;
    else if (!uv_any && is_active_mode(mode))
      rxd_o <= rx_s[1];
    else
      rxd_o <= 1'b1;
  end

  // wake detection only in low power modes with core supply valid
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      wake_detect_enable_o <= 1'b0;
    else
      wake_detect_enable_o <= ~uv_core & ~uv_bat &
                              ((mode == MODE_STANDBY) | (mode == MODE_SLEEP));
  end

  // autonomous state while core supply is low in normal or silent mode
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      autonomous_active_o <= 1'b0;
    else
      autonomous_active_o <= uv_core & ~uv_bat & is_active_mode(mode);
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      fault_indicator_n_o <= 1'b1;
    else
      fault_indicator_n_o <= ~over_temperature_shutdown;
  end

  // apb slave, zero wait states
  assign apb_acc   = psel_i & penable_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = 1'b0;
  assign rd_irq    = apb_acc & ~pwrite_i & (paddr_i == ADDR_IRQST);

  // control register
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      ctrl <= CTRL_RESET;
    else if (apb_acc && pwrite_i && (paddr_i == ADDR_CTRL))
      ctrl <= pwdata_i[1:0];
  end

  // interrupt mask register
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      irq_mask <= MASK_RESET;
    else if (apb_acc && pwrite_i && (paddr_i == ADDR_MASK))
      irq_mask <= pwdata_i[3:0];
  end

  always_comb
  begin
    prdata_o = 32'h0000_0000;
    if (paddr_i == ADDR_CTRL)
      prdata_o = {30'h0, ctrl};
    else if (paddr_i == ADDR_STATUS)
      prdata_o = {20'h0, mode, 2'h0, ev_now};
    else if (paddr_i == ADDR_IRQST)
      prdata_o = {28'h0, irq_status};
    else if (paddr_i == ADDR_MASK)
      prdata_o = {28'h0, irq_mask};
  end

  // sticky event bits, set wins over read-clear
  assign ev_now  = {uv_io, uv_core, uv_bat, over_temperature_shutdown};
  assign ev_rise = ev_now & ~ev_prev;

  // previous event levels for edge detection
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      ev_prev <= 4'h0;
    else
      ev_prev <= ev_now;
  end

  // sticky status, cleared by a read of its register
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      irq_status <= 4'h0;
    else
      irq_status <= (rd_irq ? 4'h0 : irq_status) | ev_rise;
  end

  assign irq_o = |(irq_status & irq_mask);

endmodule // can_xcvr_fault_protection

// [bench/xcvr_prot_asserts.sv]
// assertion checker for the transceiver protection supervisor
`timescale 1ns/1ps
module xcvr_prot_asserts (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic temp_above_trip_i,
  input wire logic temp_below_release_i,
  input wire logic battery_supply_undervoltage_i,
  input wire logic core_supply_undervoltage_i,
  input wire logic io_supply_undervoltage_i,
  input wire logic bus_drive_dominant_o,
  input wire logic bus_bias_recessive_o,
  input wire logic receiver_enable_o,
  input wire logic rxd_o,
  input wire logic wake_detect_enable_o,
  input wire logic fault_indicator_n_o,
  input wire logic irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire trip   = temp_above_trip_i;
  wire rel    = temp_below_release_i;
  wire flt_n  = fault_indicator_n_o;
  wire bat    = battery_supply_undervoltage_i;
  wire core   = core_supply_undervoltage_i;
  wire io     = io_supply_undervoltage_i;
  wire any_uv = bat | core | io;
  AST_TSD_DRV: assert property (trip [*6] |-> !bus_drive_dominant_o)
    else $error("driver active in thermal shutdown");
  AST_TSD_BIAS: assert property ((trip && !any_uv) [*6] |-> bus_bias_recessive_o)
    else $error("bus not recessive in thermal shutdown");
  AST_TSD_FLT: assert property (trip [*6] |-> !flt_n)
    else $error("fault output not low in thermal shutdown");
  AST_TSD_HOLD: assert property ((!rel [*4] ##0 !flt_n) ##1 !rel |-> !flt_n)
    else $error("thermal fault cleared above release level");
  AST_TSD_CLR: assert property ((rel && !trip) [*6] |-> flt_n)
    else $error("thermal fault not cleared");
  AST_SYNC: assert property ((!trip [*4] ##1 (trip && flt_n)) |=> flt_n [*2])
    else $error("fault output reacts before synchroniser");
  AST_UV_NOLOAD: assert property (any_uv [*6] |-> !(bus_bias_recessive_o ||
    bus_drive_dominant_o || receiver_enable_o))
    else $error("bus pins loaded during undervoltage");
  AST_CORE_RXD: assert property ((core && !io && !bat) [*6] |-> rxd_o && !wake_detect_enable_o)
    else $error("receive data or wake wrong in core undervoltage");
  cover property (!flt_n ##1 flt_n);
  cover property (core [*6]);
  cover property (irq_o);
endmodule // xcvr_prot_asserts

// [bench/can_ctrl_model.sv]
// behavioural protocol controller on the transmit and receive pins
`timescale 1ns/1ps
module can_ctrl_model (
  input  wire logic sys_clk_i,
  input  wire logic send_i,
  input  wire logic rxd_i,
  output logic      txd_o,
  output logic      rx_seen_o
);
  // recessive idle, dominant while sending
  assign txd_o = !send_i;
  always_ff @(posedge sys_clk_i) rx_seen_o <= rxd_i;
endmodule // can_ctrl_model

// [bench/tb_top.sv]
// testbench for the transceiver protection supervisor
`timescale 1ns/1ps
module tb_top;
  import xcvr_prot_pkg::*;
  logic        sys_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [31:0] paddr_i, pwdata_i, prdata_o, q;
  logic [2:0]  uv;
  logic        temp_above_trip_i, temp_below_release_i, txd_i, bus_rx_i, send, rx_seen;
  logic        bus_drive_dominant_o, bus_bias_recessive_o, receiver_enable_o, rxd_o;
  logic        wake_detect_enable_o, autonomous_active_o, fault_indicator_n_o, irq_o;
  int          n_mismatch, num_checks;
  can_xcvr_fault_protection #(.RECOVERY_CNT(20), .UV_FILTER_CNT(10)) u_can_xcvr_fault_protection (
    .sys_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .temp_above_trip_i, .temp_below_release_i, .battery_supply_undervoltage_i(uv[0]),
    .core_supply_undervoltage_i(uv[1]), .io_supply_undervoltage_i(uv[2]), .txd_i, .bus_rx_i,
    .bus_drive_dominant_o, .bus_bias_recessive_o, .receiver_enable_o, .rxd_o,
    .wake_detect_enable_o, .autonomous_active_o, .fault_indicator_n_o, .irq_o);
  can_ctrl_model u_can_ctrl_model (.sys_clk_i, .send_i(send), .rxd_i(rxd_o), .txd_o(txd_i),
    .rx_seen_o(rx_seen));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    @(posedge sys_clk_i);
    while (pready_o !== 1'b1) @(posedge sys_clk_i);
    q = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic mode_is(input op_mode_t m);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("mode", 32'(q[11:6]), 32'(m));
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    cyc(5000);
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, uv} = '0;
    {temp_above_trip_i, temp_below_release_i, send} = '0;
    bus_rx_i = 1'b1;
    rst_i = 1'b1;
    n_mismatch = 0;
    num_checks = 0;
    cyc(12);
    rst_i <= 1'b0;
    mode_is(MODE_RECOVER);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", q, 32'h0);
    apb(1'b0, 32'h0000_0010, 32'h0);
    chk("unmapped", q, 32'h0);
    chk("slverr", 32'(pslverr_o), 32'h0);
    cyc(30);
    mode_is(MODE_NORMAL);
    $display("test reset done");
    apb(1'b1, ADDR_CTRL, 32'h1);
    cyc(2);
    mode_is(MODE_SILENT);
    apb(1'b1, ADDR_CTRL, 32'h2);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", q, 32'h2);
    mode_is(MODE_STANDBY);
    apb(1'b1, ADDR_CTRL, 32'h0);
    cyc(2);
    mode_is(MODE_NORMAL);
    apb(1'b1, ADDR_MASK, 32'h0000_000F);
    apb(1'b0, ADDR_MASK, 32'h0);
    chk("mask", q, 32'h0000_000F);
    send <= 1'b1;
    bus_rx_i <= 1'b0;
    cyc(6);
    chk("drive", 32'(bus_drive_dominant_o), 32'h1);
    temp_above_trip_i <= 1'b1;
    cyc(6);
    chk("drive", 32'(bus_drive_dominant_o), 32'h0);
    chk("bias", 32'(bus_bias_recessive_o), 32'h1);
    chk("rxd", 32'(rxd_o), 32'h0);
    chk("rxseen", 32'(rx_seen), 32'h0);
    chk("fault", 32'(fault_indicator_n_o), 32'h0);
    chk("irq", 32'(irq_o), 32'h1);
    temp_above_trip_i <= 1'b0;
    cyc(8);
    chk("fault", 32'(fault_indicator_n_o), 32'h0);
    temp_below_release_i <= 1'b1;
    cyc(6);
    chk("fault", 32'(fault_indicator_n_o), 32'h1);
    temp_above_trip_i <= 1'b1;
    cyc(6);
    chk("fault", 32'(fault_indicator_n_o), 32'h0);
    temp_above_trip_i <= 1'b0;
    apb(1'b0, ADDR_IRQST, 32'h0);
    chk("irqst", q, 32'h1);
    cyc(6);
    chk("irq", 32'(irq_o), 32'h0);
    chk("fault", 32'(fault_indicator_n_o), 32'h1);
    $display("test thermal done");
    apb(1'b1, ADDR_MASK, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      uv <= 3'(1 << i);
      cyc(6);
      mode_is(i == 0 ? MODE_OFF : i == 1 ? MODE_NORMAL : MODE_STANDBY);
      chk("noload", 32'({bus_bias_recessive_o, bus_drive_dominant_o, receiver_enable_o}), 32'h0);
      chk("irq", 32'(irq_o), 32'h0);
      if (i == 1)
      begin
        chk("auto", 32'({autonomous_active_o, rxd_o, wake_detect_enable_o}), 32'h6);
      end
      apb(1'b1, ADDR_MASK, 32'h0000_000F);
      cyc(1);
      chk("irq", 32'(irq_o), 32'h1);
      apb(1'b0, ADDR_IRQST, 32'h0);
      chk("irqst", q, 32'(2 << i));
      apb(1'b1, ADDR_MASK, 32'h0);
      cyc(12);
      if (i > 0) mode_is(MODE_SLEEP);
      uv <= 3'h0;
      cyc(10);
      mode_is(MODE_RECOVER);
      cyc(30);
      mode_is(MODE_NORMAL);
    end
    uv <= 3'h4;
    cyc(4);
    uv <= 3'h0;
    cyc(4);
    mode_is(MODE_RECOVER);
    cyc(30);
    mode_is(MODE_NORMAL);
    $display("test undervoltage done");
    end_of_test();
  end
endmodule // tb_top
bind can_xcvr_fault_protection xcvr_prot_asserts u_xcvr_prot_asserts (.sys_clk_i, .rst_i,
  .temp_above_trip_i, .temp_below_release_i, .battery_supply_undervoltage_i,
  .core_supply_undervoltage_i, .io_supply_undervoltage_i, .bus_drive_dominant_o,
  .bus_bias_recessive_o, .receiver_enable_o, .rxd_o, .wake_detect_enable_o,
  .fault_indicator_n_o, .irq_o);
